/* File: lfs_defs.svh */
`ifndef LFS_DEFS_SVH
`define LFS_DEFS_SVH

// Register byte offsets on the APB bus.
`define LFS_OFS_STATUS   8'h00
`define LFS_OFS_CONTROL  8'h04
`define LFS_OFS_DISPLAY  8'h08
`define LFS_OFS_COUNT    8'h0C

// Control, display and count register fields.
`define LFS_CTL_ALLOW    0
`define LFS_CTL_CLEAR    1
`define LFS_DISP_VALID   8
`define LFS_CNT_TRIG_LO  8

// Alarm bit positions.
`define LFS_ER_INTLK     11
`define LFS_ER_FUSE1     6
`define LFS_ER_FUSE2     7
`define LFS_ER_BACKREF   8
`define LFS_ER_UNDERPW   9
`define LFS_ER_OVERPW    10
`define LFS_ER_FIBLOOP   12
`define LFS_ER_EXTMIS    13
`define LFS_ER_SUPSTART  14
`define LFS_ER_STARTDIAG 15
`define LFS_ER_SUPEARLY  16
`define LFS_ER_SUPLATE   17
`define LFS_ER_EXTB_SD   18
`define LFS_ER_EXTA_SD   19
`define LFS_ER_FIBER_SD  20
`define LFS_ER_NOZZ_SD   21
`define LFS_ER_TRIG_SD   22
`define LFS_ER_VOLT      23
`define LFS_ER_CURR      24
`define LFS_ER_NOZZ_UP   25
`define LFS_ER_TRIG_UP   26
`define LFS_ER_THERMAL   27
`define LFS_ER_NOZZ_CNT  28
`define LFS_ER_TRIG_CNT  29
`define LFS_ER_GAS       30
`define LFS_ER_FAN       31

// Alarms cleared only by a power cycle.
`define LFS_POWER_ONLY   32'h0003C800
// Reset values.
`define LFS_ALARM_RST    32'h00000000
`define LFS_CNT_RST      5'h00

// Emission counting and timing.
`define LFS_EMIT_LIMIT   5'h19
`define LFS_CLK_HZ       20000000
`define LFS_FAN_DELAY_S  30
`define LFS_GAS_DELAY_MS 100

`endif

/* File: lfs_pkg.sv */
package lfs_pkg;

	// Emission sequencing states.
	typedef enum logic [1:0] {
		LFS_EM_IDLE,
		LFS_EM_START,
		LFS_EM_RUN
	} lfs_emis_e;

	typedef logic [31:0] lfs_alarm_t;

endpackage

/* File: lfs_supervisor.sv */
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/100ps
`include "lfs_defs.svh"

module lfs_supervisor #(
	parameter int FAN_DELAY_CYC = `LFS_FAN_DELAY_S * `LFS_CLK_HZ,
	parameter int GAS_DELAY_CYC = `LFS_GAS_DELAY_MS * (`LFS_CLK_HZ / 1000)
) (
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Interlocks high when closed; trigger 2 high when pressed, faults high, start checks high when ok.
	input  wire logic        nozzle_closed,
	input  wire logic        trig1_closed,
	input  wire logic        trig2_pressed,
	input  wire logic        fiber_closed,
	input  wire logic        ext_a_closed,
	input  wire logic        ext_b_closed,
	input  wire logic        fiber_loop_fault,
	input  wire logic        safety_loop_fault,
	input  wire logic        remote_start_ok,
	input  wire logic        all_safe_ok,
	// Laser supply and optical monitors.
	input  wire logic        supply_enable,
	input  wire logic        supply_volt_ok,
	input  wire logic        supply_curr_ok,
	input  wire logic        fuse1_over,
	input  wire logic        fuse2_over,
	input  wire logic        back_refl_over,
	input  wire logic        power_under,
	input  wire logic        power_over,
	input  wire logic        thermal_hot,
	// Gas, fans and emission request.
	input  wire logic        gas_ok,
	input  wire logic        fan1_spin,
	input  wire logic        fan2_spin,
	input  wire logic        emission_req,
	// Outputs to the laser and front panel.
	output logic             emission_on,
	output logic             error_led,
	output logic [4:0]       display_code,
	output logic             display_valid
);

	// Returns the index of the highest set bit.
	function automatic logic [4:0] top_bit(input logic [31:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 0; i < 32; i++) begin
			if (v[i]) begin
				r = 5'(i);
			end
		end
		return r;
	endfunction

	lfs_pkg::lfs_alarm_t alarm;
	lfs_pkg::lfs_alarm_t next_alarm;
	lfs_pkg::lfs_alarm_t set_vec;
	lfs_pkg::lfs_alarm_t cause_gone;
	lfs_pkg::lfs_alarm_t clr_vec;
	lfs_pkg::lfs_emis_e  state;
	lfs_pkg::lfs_emis_e  next_state;
	logic        start_done;
	logic        at_start;
	logic        emis_prev;
	logic        req_prev;
	logic        trig1_prev;
	logic        allow;
	logic        sw_clear;
	logic [4:0]  nozz_cnt;
	logic [4:0]  trig_cnt;
	logic [29:0] fan_timer;
	logic [29:0] gas_timer;
	logic        fan_armed;
	logic        gas_ready;
	logic        wr_en;
	logic        rd_setup;
	logic        addr_ok;
	logic        trig_press;
	logic        clr_req;
	logic        interlocks_ok;
	logic        emis_rise;
	logic        req_rise;
	logic        running;
	logic [31:0] rd_mux;

	// APB decode; every access completes in the access cycle.
	assign addr_ok  = (paddr == `LFS_OFS_STATUS) || (paddr == `LFS_OFS_CONTROL) ||
		(paddr == `LFS_OFS_DISPLAY) || (paddr == `LFS_OFS_COUNT);
	assign wr_en    = psel && penable && pwrite && addr_ok;
	assign rd_setup = psel && !penable && !pwrite;
	assign pready   = psel && penable;
	assign pslverr  = psel && penable && !addr_ok;
	assign sw_clear = wr_en && (paddr == `LFS_OFS_CONTROL) && pwdata[`LFS_CTL_CLEAR];

	// Read data selection; the whole alarm set is one word.
	assign rd_mux = (paddr == `LFS_OFS_STATUS)  ? alarm :
		(paddr == `LFS_OFS_CONTROL) ? {31'h00000000, allow} :
		(paddr == `LFS_OFS_DISPLAY) ? {23'h000000, display_valid, 3'h0, display_code} :
		(paddr == `LFS_OFS_COUNT)   ? {19'h00000, trig_cnt, 3'h0, nozz_cnt} :
		32'h00000000;

	// Read data is captured in the setup cycle and held through the access.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (rd_setup) begin
			prdata <= rd_mux;
		end
	end

	// Software emission permission.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			allow <= 1'b0;
		end else if (wr_en && paddr == `LFS_OFS_CONTROL) begin
			allow <= pwdata[`LFS_CTL_ALLOW];
		end
	end

	// Edge history and the one-cycle startup sample window.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_done <= 1'b0;
			emis_prev  <= 1'b0;
			req_prev   <= 1'b0;
			trig1_prev <= 1'b1;
		end else begin
			start_done <= 1'b1;
			emis_prev  <= emission_on;
			req_prev   <= emission_req;
			trig1_prev <= trig1_closed;
		end
	end
	assign at_start = !start_done;

	// A clear attempt comes from software or from a fresh trigger-1 press.
	assign trig_press = trig1_closed && !trig1_prev && !trig2_pressed;
	assign clr_req    = sw_clear || trig_press;

	// Fan monitor starts after the startup delay; gas pre-flow timer.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fan_timer <= 30'h00000000;
			gas_timer <= 30'h00000000;
		end else begin
			if (!fan_armed) begin
				fan_timer <= fan_timer + 30'h00000001;
			end
			if (!gas_ok) begin
				gas_timer <= 30'h00000000;
			end else if (!gas_ready) begin
				gas_timer <= gas_timer + 30'h00000001;
			end
		end
	end
	assign fan_armed = fan_timer >= 30'(FAN_DELAY_CYC);
	assign gas_ready = gas_timer >= 30'(GAS_DELAY_CYC);

	// Emission sequencing: start cycle checks the supply, then run.
	assign interlocks_ok = nozzle_closed && trig1_closed && fiber_closed && ext_a_closed && ext_b_closed;
	assign running       = state != lfs_pkg::LFS_EM_IDLE;
	assign emis_rise     = state == lfs_pkg::LFS_EM_START;
	assign req_rise      = emission_req && !req_prev;

	// Any alarm or open interlock drops emission on the next edge.
	always_comb begin
		next_state = state;
		unique case (state)
			lfs_pkg::LFS_EM_IDLE: begin
				if (emission_req && allow && gas_ready && interlocks_ok && alarm == 32'h00000000 && start_done) begin
					next_state = lfs_pkg::LFS_EM_START;
				end
			end
			lfs_pkg::LFS_EM_START, lfs_pkg::LFS_EM_RUN: begin
				if (!emission_req || !interlocks_ok || !allow || next_alarm != 32'h00000000) begin
					next_state = lfs_pkg::LFS_EM_IDLE;
				end else begin
					next_state = lfs_pkg::LFS_EM_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state       <= lfs_pkg::LFS_EM_IDLE;
			emission_on <= 1'b0;
		end else begin
			state       <= next_state;
			emission_on <= next_state != lfs_pkg::LFS_EM_IDLE;
		end
	end

	// Emission counters since the nozzle or trigger-1 last opened.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nozz_cnt <= `LFS_CNT_RST;
			trig_cnt <= `LFS_CNT_RST;
		end else begin
			if (!nozzle_closed) begin
				nozz_cnt <= `LFS_CNT_RST;
			end else if (emis_rise && nozz_cnt != `LFS_EMIT_LIMIT) begin
				nozz_cnt <= nozz_cnt + 5'h01;
			end
			if (!trig1_closed) begin
				trig_cnt <= `LFS_CNT_RST;
			end else if (emis_rise && trig_cnt != `LFS_EMIT_LIMIT) begin
				trig_cnt <= trig_cnt + 5'h01;
			end
		end
	end

	// Alarm causes, one term per bit.
	always_comb begin
		set_vec = 32'h00000000;
		set_vec[`LFS_ER_FUSE1]     = fuse1_over;
		set_vec[`LFS_ER_FUSE2]     = fuse2_over;
		set_vec[`LFS_ER_BACKREF]   = back_refl_over;
		set_vec[`LFS_ER_UNDERPW]   = power_under;
		set_vec[`LFS_ER_OVERPW]    = power_over;
		set_vec[`LFS_ER_INTLK]     = safety_loop_fault;
		set_vec[`LFS_ER_FIBLOOP]   = fiber_loop_fault;
		set_vec[`LFS_ER_EXTMIS]    = ext_a_closed != ext_b_closed;
		set_vec[`LFS_ER_SUPSTART]  = at_start && supply_enable;
		set_vec[`LFS_ER_STARTDIAG] = at_start && (!fiber_closed || !remote_start_ok || !all_safe_ok);
		set_vec[`LFS_ER_SUPEARLY]  = start_done && !running && !emis_prev && supply_enable;
		set_vec[`LFS_ER_SUPLATE]   = emis_rise && !supply_enable;
		set_vec[`LFS_ER_EXTB_SD]   = running && !ext_b_closed;
		set_vec[`LFS_ER_EXTA_SD]   = running && !ext_a_closed;
		set_vec[`LFS_ER_FIBER_SD]  = running && !fiber_closed;
		set_vec[`LFS_ER_NOZZ_SD]   = running && !nozzle_closed;
		set_vec[`LFS_ER_TRIG_SD]   = running && !trig1_closed;
		set_vec[`LFS_ER_VOLT]      = emis_rise && !supply_volt_ok;
		set_vec[`LFS_ER_CURR]      = running && !supply_curr_ok;
		set_vec[`LFS_ER_NOZZ_UP]   = at_start && nozzle_closed;
		set_vec[`LFS_ER_TRIG_UP]   = at_start && trig1_closed;
		set_vec[`LFS_ER_THERMAL]   = thermal_hot;
		set_vec[`LFS_ER_NOZZ_CNT]  = nozz_cnt == `LFS_EMIT_LIMIT;
		set_vec[`LFS_ER_TRIG_CNT]  = trig_cnt == `LFS_EMIT_LIMIT;
		set_vec[`LFS_ER_GAS]       = (running && !gas_ok) || (req_rise && !gas_ready);
		set_vec[`LFS_ER_FAN]       = fan_armed && (!fan1_spin || !fan2_spin);
	end

	// Extra conditions a bit needs before a clear may take it.
	always_comb begin
		cause_gone = ~set_vec;
		cause_gone[`LFS_ER_FIBLOOP]  = !fiber_loop_fault && !fiber_closed;
		cause_gone[`LFS_ER_EXTMIS]   = !ext_a_closed && !ext_b_closed;
		cause_gone[`LFS_ER_NOZZ_UP]  = !nozzle_closed;
		cause_gone[`LFS_ER_TRIG_UP]  = !trig1_closed;
		cause_gone[`LFS_ER_THERMAL]  = !thermal_hot && !running;
		cause_gone[`LFS_ER_NOZZ_CNT] = !nozzle_closed;
		cause_gone[`LFS_ER_TRIG_CNT] = !trig1_closed;
	end

	// Set wins over clear; power-cycle alarms never take a clear.
	assign clr_vec    = clr_req ? (cause_gone & ~`LFS_POWER_ONLY) : 32'h00000000;
	assign next_alarm = (alarm & ~clr_vec) | set_vec;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm <= `LFS_ALARM_RST;
		end else begin
			alarm <= next_alarm;
		end
	end

	// Front panel shows the most severe alarm only.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			display_code  <= 5'h00;
			display_valid <= 1'b0;
			error_led     <= 1'b0;
		end else begin
			display_code  <= top_bit(next_alarm);
			display_valid <= next_alarm != 32'h00000000;
			error_led     <= next_alarm != 32'h00000000;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_emis_start;
		state == lfs_pkg::LFS_EM_START;
	endsequence

	sequence s_running_fiber_open;
		running && !fiber_closed;
	endsequence

	// The startup sample cycle, seen only once reset has been released.
	sequence s_startup;
		presetn && at_start;
	endsequence

	a_fuse_latch: assert property (fuse1_over ##1 (fuse1_over || !clr_req) |-> alarm[`LFS_ER_FUSE1] [*2])
		else $error("Fiber fuse alarm not latched.");
	a_under_clear: assert property (clr_req && alarm[`LFS_ER_UNDERPW] && !power_under |=> !alarm[`LFS_ER_UNDERPW])
		else $error("Under power alarm not cleared.");
	a_under_hold: assert property (clr_req && power_under |=> alarm[`LFS_ER_UNDERPW])
		else $error("Under power alarm cleared while cause present.");
	a_power_only: assert property (alarm[`LFS_ER_SUPLATE] |=> alarm[`LFS_ER_SUPLATE])
		else $error("Power-cycle alarm cleared.");
	a_ext_hold: assert property (alarm[`LFS_ER_EXTMIS] && (ext_a_closed || ext_b_closed) |=> alarm[`LFS_ER_EXTMIS])
		else $error("Channel mismatch alarm cleared with a channel closed.");
	a_supply_late: assert property (s_emis_start ##0 !supply_enable |=> alarm[`LFS_ER_SUPLATE])
		else $error("Late supply enable not flagged.");
	a_fiber_shut: assert property (s_running_fiber_open |=> alarm[`LFS_ER_FIBER_SD] && !emission_on)
		else $error("Fiber interlock did not shut emission.");
	a_count_limit: assert property (nozzle_closed && nozz_cnt == `LFS_EMIT_LIMIT |=> alarm[`LFS_ER_NOZZ_CNT])
		else $error("Nozzle emission count alarm missing.");
	a_gas_loss: assert property (running && !gas_ok |=> alarm[`LFS_ER_GAS] ##1 !emission_on)
		else $error("Gas loss not handled.");
	a_display_top: assert property (alarm[`LFS_ER_FAN] |-> display_code == 5'h1F && display_valid)
		else $error("Display not showing highest alarm.");

	// The external A, nozzle and trigger-1 interlocks opening during emission must stop it as well.
	a_exta_shut: assert property (running && !ext_a_closed |=> alarm[`LFS_ER_EXTA_SD] && !emission_on)
		else $error("External A opening did not shut emission.");
	a_nozz_shut: assert property (running && !nozzle_closed |=> alarm[`LFS_ER_NOZZ_SD] && !emission_on)
		else $error("Nozzle opening did not shut emission.");
	a_trig_shut: assert property (running && !trig1_closed |=> alarm[`LFS_ER_TRIG_SD] && !emission_on)
		else $error("Trigger opening did not shut emission.");

	// Startup samples, start checks, conditional clears and the fan alarm.
	a_start_supply: assert property (s_startup ##0 supply_enable |=> alarm[`LFS_ER_SUPSTART])
		else $error("Supply enabled at startup not flagged.");
	a_volt_start: assert property (s_emis_start ##0 !supply_volt_ok |=> alarm[`LFS_ER_VOLT])
		else $error("Supply voltage fault at start not flagged.");
	a_nozz_up_hold: assert property (alarm[`LFS_ER_NOZZ_UP] && nozzle_closed |=> alarm[`LFS_ER_NOZZ_UP])
		else $error("Nozzle startup alarm cleared with nozzle closed.");
	a_thermal_hold: assert property (alarm[`LFS_ER_THERMAL] && thermal_hot |=> alarm[`LFS_ER_THERMAL])
		else $error("Thermal alarm cleared while still hot.");
	a_press_clear: assert property (trig_press && alarm[`LFS_ER_FUSE1] && !fuse1_over |=> !alarm[`LFS_ER_FUSE1])
		else $error("Trigger press did not clear a resolved alarm.");
	a_fan_alarm: assert property (fan_armed && !fan1_spin |=> alarm[`LFS_ER_FAN])
		else $error("Stopped fan not flagged.");

endmodule

/* File: lfs_far_model.sv */
`timescale 1ns/100ps

// Laser supply behind the supervisor; the bench commands its faults.
module lfs_far_model (
	// Commands from the bench.
	input  wire logic       emission_on,
	input  wire logic [1:0] sup_mode,
	input  wire logic       volt_bad,
	input  wire logic       curr_bad,
	// Supply status towards the supervisor.
	output logic            supply_enable,
	output logic            supply_volt_ok,
	output logic            supply_curr_ok
);
	// Mode 0 follows emission, mode 1 sticks on, mode 2 never enables.
	assign supply_enable  = (sup_mode == 2'h1) | ((sup_mode == 2'h0) & emission_on);
	assign supply_volt_ok = ~volt_bad;
	assign supply_curr_ok = ~curr_bad;
endmodule

/* File: tb_top.sv */
`timescale 1ns/100ps

module tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        emission_on, error_led, display_valid, sup_en, v_ok, c_ok;
	logic [4:0]  display_code, ilk;
	logic [5:0]  cond;
	logic [1:0]  sup_mode;
	logic        volt_bad, curr_bad, trig2, floop, sloop, rs_ok, as_ok, gas, fan1, fan2, req;
	int          n_fail, checked, tmo;

	lfs_supervisor #(.FAN_DELAY_CYC(20), .GAS_DELAY_CYC(5)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.nozzle_closed(ilk[3]), .trig1_closed(ilk[4]), .trig2_pressed(trig2), .fiber_closed(ilk[2]),
		.ext_a_closed(ilk[1]), .ext_b_closed(ilk[0]), .fiber_loop_fault(floop), .safety_loop_fault(sloop),
		.remote_start_ok(rs_ok), .all_safe_ok(as_ok), .supply_enable(sup_en), .supply_volt_ok(v_ok),
		.supply_curr_ok(c_ok), .fuse1_over(cond[0]), .fuse2_over(cond[1]), .back_refl_over(cond[2]),
		.power_under(cond[3]), .power_over(cond[4]), .thermal_hot(cond[5]), .gas_ok(gas),
		.fan1_spin(fan1), .fan2_spin(fan2), .emission_req(req), .emission_on(emission_on),
		.error_led(error_led), .display_code(display_code), .display_valid(display_valid)
	);

	lfs_far_model far_u (
		.emission_on(emission_on), .sup_mode(sup_mode), .volt_bad(volt_bad), .curr_bad(curr_bad),
		.supply_enable(sup_en), .supply_volt_ok(v_ok), .supply_curr_ok(c_ok)
	);

	// Free-running 20 MHz clock.
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	// Cuts a hung run short.
	always @(posedge pclk) begin
		tmo++;
		if (tmo == 20000) begin
			n_fail++;
			results;
		end
	end

	task automatic results;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// One APB transfer, held until pready is sampled high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic st(input logic [31:0] e);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, e);
	endtask

	// Keeps allow set and requests a clear.
	task automatic clr;
		apb(1'b1, 8'h04, 32'h00000003);
	endtask

	// Opens every interlock, clears, then closes them again.
	task automatic clr_all;
		ilk <= 5'h00;
		cyc(2);
		clr;
		ilk <= 5'h1F;
		cyc(2);
	endtask

	task automatic emit;
		req <= 1'b1;
		for (int i = 0; i < 20 && emission_on !== 1'b1; i++) @(posedge pclk);
	endtask

	task automatic stop;
		req <= 1'b0;
		for (int i = 0; i < 20 && emission_on !== 1'b0; i++) @(posedge pclk);
	endtask

	task automatic do_reset;
		presetn <= 1'b0;
		cyc(6);
		presetn <= 1'b1;
		cyc(3);
	endtask

	// Main sequence.
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		ilk = 5'h07;
		cond = 6'h00;
		sup_mode = 2'h0;
		volt_bad = 1'b0;
		curr_bad = 1'b0;
		trig2 = 1'b0;
		floop = 1'b0;
		sloop = 1'b0;
		rs_ok = 1'b1;
		as_ok = 1'b1;
		gas = 1'b1;
		fan1 = 1'b1;
		fan2 = 1'b1;
		req = 1'b0;
		n_fail = 0;
		checked = 0;
		tmo = 0;
		do_reset;
		st(32'h0);
		apb(1'b0, 8'h0C, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, 8'h10, 32'hFFFFFFFF);
		apb(1'b0, 8'h10, 32'h0);
		chk({rd[31:1], slv}, 32'h1);
		apb(1'b1, 8'h04, 32'h00000001);
		ilk <= 5'h1F;
		cyc(2);
		$display("test registers done");
		for (int i = 0; i < 6; i++) begin
			cond <= 6'h01 << i;
			cyc(2);
			clr;
			st(32'h1 << (i == 5 ? 27 : 6 + i));
			cond <= 6'h00;
			cyc(1);
			st(32'h1 << (i == 5 ? 27 : 6 + i));
			clr;
			st(32'h0);
		end
		cond <= 6'h11;
		cyc(2);
		cond <= 6'h00;
		apb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h0000010A);
		clr;
		// A trigger-1 press clears only while trigger 2 is released.
		cond <= 6'h01;
		cyc(2);
		cond <= 6'h00;
		trig2 <= 1'b1;
		ilk <= 5'h0F;
		cyc(2);
		ilk <= 5'h1F;
		cyc(2);
		st(32'h00000040);
		trig2 <= 1'b0;
		ilk <= 5'h0F;
		cyc(2);
		ilk <= 5'h1F;
		cyc(2);
		st(32'h0);
		$display("test monitors done");
		for (int i = 0; i < 5; i++) begin
			emit;
			ilk <= 5'h1F & ~(5'h01 << i);
			cyc(2);
			chk({31'h0, emission_on}, 32'h0);
			chk({27'h0, display_code}, 18 + i);
			chk({30'h0, error_led, display_valid}, 32'h3);
			st((32'h1 << (18 + i)) | (i < 2 ? 32'h2000 : 32'h0));
			stop;
			clr_all;
			st(32'h0);
		end
		$display("test interlocks done");
		ilk <= 5'h1D;
		cyc(2);
		clr;
		st(32'h2000);
		clr_all;
		st(32'h0);
		floop <= 1'b1;
		cyc(2);
		floop <= 1'b0;
		clr;
		st(32'h1000);
		clr_all;
		st(32'h0);
		volt_bad <= 1'b1;
		emit;
		cyc(2);
		volt_bad <= 1'b0;
		st(32'h00800000);
		stop;
		clr_all;
		emit;
		curr_bad <= 1'b1;
		cyc(2);
		curr_bad <= 1'b0;
		st(32'h01000000);
		stop;
		clr_all;
		emit;
		gas <= 1'b0;
		cyc(2);
		gas <= 1'b1;
		st(32'h40000000);
		stop;
		cyc(8);
		clr_all;
		gas <= 1'b0;
		cyc(1);
		gas <= 1'b1;
		cyc(1);
		req <= 1'b1;
		cyc(3);
		chk({31'h0, emission_on}, 32'h0);
		req <= 1'b0;
		st(32'h40000000);
		cyc(8);
		clr_all;
		fan1 <= 1'b0;
		cyc(2);
		clr;
		st(32'h80000000);
		fan1 <= 1'b1;
		cyc(1);
		clr;
		st(32'h0);
		$display("test supply gas fan done");
		for (int i = 0; i < 24; i++) begin
			emit;
			stop;
		end
		apb(1'b0, 8'h0C, 32'h0);
		chk(rd, 32'h00001818);
		emit;
		cyc(2);
		st(32'h30000000);
		stop;
		clr_all;
		st(32'h0);
		$display("test counts done");
		sup_mode <= 2'h2;
		emit;
		cyc(2);
		st(32'h00020000);
		stop;
		sloop <= 1'b1;
		cyc(2);
		sloop <= 1'b0;
		sup_mode <= 2'h1;
		cyc(2);
		clr_all;
		st(32'h00030800);
		ilk <= 5'h1B;
		do_reset;
		st(32'h0601C000);
		clr;
		st(32'h0601C000);
		ilk <= 5'h03;
		cyc(2);
		clr;
		st(32'h0001C000);
		$display("test power cycle done");
		results;
	end
endmodule
